/* src/serial_port_cfg.svh */
// Register offsets, field positions, reset values and counts of the serial port.
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
`define CTRL_OFS 2'h0
`define DATA_OFS 2'h1
`define RATE_OFS 2'h2
`define CTRL_RST 8'h00
`define RATE_RST 8'h00
`define BUF_RST 8'h00
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_MP_EN 5
`define F_RX_EN 4
`define F_TX_B9 3
`define F_RX_B9 2
`define F_TX_DONE 1
`define F_RX_DONE 0
`define F_RATE_DBL 7
`define F_TX_T2 1
`define F_RX_T2 0
`define OVS_LAST 4'hf
`define OVS_MID 4'h7
`define FIX_DIV_LAST 2'h3
`define M0_LAST 4'h7
`define RX_LAST_B8 4'h7
`define RX_LAST_B9 4'h8
`define TX_LAST_B8 4'h9
`define TX_LAST_B9 4'ha
`endif

/* src/serial_port_pkg.sv */
// Types shared by the serial port: modes, receiver states and the state record.
package serial_port_pkg;
   typedef enum logic [1:0] {
      MODE_SHIFT  = 2'h0,
      MODE_ASYNC8 = 2'h1,
      MODE_FIX9   = 2'h2,
      MODE_VAR9   = 2'h3
   } mode_t;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h3,
      RX_STOP  = 2'h2
   } rx_state_t;
   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  rate;
      logic [7:0]  rx_buf;
      logic [7:0]  rdata;
      logic [10:0] tx_sh;
      logic [3:0]  tx_bit;
      logic [3:0]  tx_sub;
      logic        tx_busy;
      logic        tx_pend;
      logic        m0_busy;
      logic        m0_rx;
      logic        m0_ph;
      logic [3:0]  m0_bit;
      logic [7:0]  m0_sh;
      rx_state_t   rx_st;
      logic [8:0]  rx_sh;
      logic [3:0]  rx_bit;
      logic [3:0]  rx_sub;
      logic        rx_prev;
      logic [1:0]  pre;
      logic        t1_half;
      logic        txd;
      logic        rxd_out;
      logic        rxd_oe;
   } state_t;
endpackage

/* src/four_mode_serial_port.sv */
// Four-mode serial port: shift-register mode and three asynchronous framings.
`timescale 1ns/1ps
`include "serial_port_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Two mode bits pick shift, 8-bit async, 9-bit fixed or 9-bit variable.
// - Receive-enable gates the start of reception; clearing it stops async reception, but a running shift reception completes.
// - In 9-bit modes the transmit ninth-bit field goes out as ninth bit.
// - Receive ninth-bit holds ninth bit in 9-bit modes, stop bit in 8-bit async.
// - Transmit-done sets after bit eight (shift) or at stop start; software clears.
// - Receive-done sets after bit eight (shift) or mid stop bit; software clears.
// - Shift mode moves eight bits LSB first on receive pin, clock on transmit.
// - Shift mode reception starts when receive-enable is 1 and receive-done is 0.
// - Any write of the data buffer starts a transmission, except one made while a shift-mode transfer runs.
// - 8-bit async frame: start 0, eight data bits LSB first, stop 1.
// - 8-bit async buffer write loads 1 into the ninth transmit position.
// - Async reception starts on a falling edge; start bit not stored.
// - Last bit moves data to buffer; done set if clear and stop or mp ok.
// - 9-bit fixed rate is clock over 64, or over 32 when doubled.
// - 9-bit frames carry start, eight data, ninth bit and stop: eleven bits.
// - 9-bit transmit loads data and ninth bit, shifting from next rate tick.
// - 9-bit variable mode equals fixed mode but takes timer overflow rate.
// - Variable rate comes from either timer, separately for transmit and receive.
// - Async start bit starts a reception only while receive-enable is 1.
// - Buffer writes load transmit register; reads return separate receive register.
// - Reception is buffered; in async modes an unread frame is overwritten by the next.
// - First timer rate: overflow rate over 32, or over 16 when doubled.
// - Second timer: sixteen overflows make one bit period.
module four_mode_serial_port (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       T1_OVF,
   input  wire logic       T2_OVF,
   input  wire logic       RXD_IN,
   output logic            RXD_OUT,
   output logic            RXD_OE,
   output logic            TXD
);

   serial_port_pkg::state_t s_reg;
   serial_port_pkg::state_t s_next;
   serial_port_pkg::mode_t  mode;
   logic                    dbl;
   logic                    fix_tick;
   logic                    t1_tick;
   logic                    tx_tick;
   logic                    rx_tick;
   logic                    wr_data;
   logic [3:0]              tx_last;
   logic [3:0]              rx_last;
   logic [7:0]              rx_data;

   ////////////////////////////////////////////////////////////////////////////
   // Rate ticks at sixteen times the bit rate.

   assign mode = serial_port_pkg::mode_t'(s_reg.ctl[`F_MODE_HI:`F_MODE_LO]);
   assign dbl  = s_reg.rate[`F_RATE_DBL];
   // Four clocks per sixteenth gives clock over 64; two give clock over 32.
   assign fix_tick = dbl ? s_reg.pre[0] : (s_reg.pre == `FIX_DIV_LAST);
   // The first timer is halved unless doubled, so a bit spans 32 or 16 overflows.
   assign t1_tick = T1_OVF & (s_reg.t1_half | dbl);
   always_comb begin
      if (mode == serial_port_pkg::MODE_FIX9) begin
         tx_tick = fix_tick;
         rx_tick = fix_tick;
      end else begin
         tx_tick = s_reg.rate[`F_TX_T2] ? T2_OVF : t1_tick;
         rx_tick = s_reg.rate[`F_RX_T2] ? T2_OVF : t1_tick;
      end
   end

   assign wr_data = WR && (ADDR == `DATA_OFS);
   assign tx_last = (mode == serial_port_pkg::MODE_ASYNC8) ? `TX_LAST_B8 : `TX_LAST_B9;
   assign rx_last = (mode == serial_port_pkg::MODE_ASYNC8) ? `RX_LAST_B8 : `RX_LAST_B9;
   assign rx_data = (mode == serial_port_pkg::MODE_ASYNC8) ? s_reg.rx_sh[8:1]
                                                           : s_reg.rx_sh[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      s_next = s_reg;
      s_next.pre = s_reg.pre + 2'h1;
      if (T1_OVF) begin
         s_next.t1_half = ~s_reg.t1_half;
      end

      // Register port; software writes land first so hardware sets win.
      s_next.rdata = 8'h00;
      if (RD) begin
         if (ADDR == `CTRL_OFS) begin
            s_next.rdata = s_reg.ctl;
         end else if (ADDR == `DATA_OFS) begin
            s_next.rdata = s_reg.rx_buf;
         end else if (ADDR == `RATE_OFS) begin
            s_next.rdata = s_reg.rate;
         end
      end
      if (WR) begin
         if (ADDR == `CTRL_OFS) begin
            s_next.ctl = WDATA;
         end else if (ADDR == `RATE_OFS) begin
            s_next.rate = WDATA;
         end
      end

      // Asynchronous transmitter.
      if (mode != serial_port_pkg::MODE_SHIFT) begin
         if (wr_data) begin
            // Word is stop, ninth, data, start; shifted out from bit 0.
            s_next.tx_sh = {1'b1,
                            (mode == serial_port_pkg::MODE_ASYNC8) ? 1'b1
                                                   : s_reg.ctl[`F_TX_B9],
                            WDATA, 1'b0};
            s_next.tx_pend = 1'b1;
            s_next.tx_busy = 1'b0;
            s_next.txd     = 1'b1;
         end else if (s_reg.tx_pend && tx_tick) begin
            s_next.tx_pend = 1'b0;
            s_next.tx_busy = 1'b1;
            s_next.tx_bit  = 4'h0;
            s_next.tx_sub  = 4'h0;
            s_next.txd     = s_reg.tx_sh[0];
         end else if (s_reg.tx_busy && tx_tick) begin
            s_next.tx_sub = s_reg.tx_sub + 4'h1;
            if (s_reg.tx_sub == `OVS_LAST) begin
               if (s_reg.tx_bit == tx_last) begin
                  s_next.tx_busy = 1'b0;
                  s_next.txd     = 1'b1;
               end else begin
                  s_next.tx_bit = s_reg.tx_bit + 4'h1;
                  s_next.tx_sh  = {1'b1, s_reg.tx_sh[10:1]};
                  s_next.txd    = s_reg.tx_sh[1];
                  if (s_reg.tx_bit + 4'h1 == tx_last) begin
                     s_next.ctl[`F_TX_DONE] = 1'b1;
                  end
               end
            end
         end
      end

      // Asynchronous receiver with sixteen ticks per bit, sampling each bit once at tick 7.
      s_next.rx_prev = RXD_IN;
      case (s_reg.rx_st)
         serial_port_pkg::RX_IDLE: begin
            if (s_reg.ctl[`F_RX_EN] && s_reg.rx_prev && !RXD_IN) begin
               s_next.rx_st  = serial_port_pkg::RX_START;
               s_next.rx_sub = 4'h0;
            end
         end
         serial_port_pkg::RX_START: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `OVS_MID && RXD_IN) begin
                  s_next.rx_st = serial_port_pkg::RX_IDLE;
               end else if (s_reg.rx_sub == `OVS_LAST) begin
                  s_next.rx_st  = serial_port_pkg::RX_DATA;
                  s_next.rx_bit = 4'h0;
               end
            end
         end
         serial_port_pkg::RX_DATA: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `OVS_MID) begin
                  s_next.rx_sh = {RXD_IN, s_reg.rx_sh[8:1]};
               end
               if (s_reg.rx_sub == `OVS_LAST) begin
                  s_next.rx_bit = s_reg.rx_bit + 4'h1;
                  if (s_reg.rx_bit == rx_last) begin
                     s_next.rx_st = serial_port_pkg::RX_STOP;
                  end
               end
            end
         end
         serial_port_pkg::RX_STOP: begin
            if (rx_tick) begin
               s_next.rx_sub = s_reg.rx_sub + 4'h1;
               if (s_reg.rx_sub == `OVS_MID) begin
                  s_next.rx_st  = serial_port_pkg::RX_IDLE;
                  s_next.rx_buf = rx_data;
                  s_next.ctl[`F_RX_B9] = (mode == serial_port_pkg::MODE_ASYNC8) ? RXD_IN
                                                                : s_reg.rx_sh[8];
                  if (!s_reg.ctl[`F_RX_DONE] && (!s_reg.ctl[`F_MP_EN] || RXD_IN)) begin
                     s_next.ctl[`F_RX_DONE] = 1'b1;
                  end
               end
            end
         end
         default: begin
            s_next.rx_st = serial_port_pkg::RX_IDLE;
         end
      endcase
      if (!s_reg.ctl[`F_RX_EN] || mode == serial_port_pkg::MODE_SHIFT) begin
         s_next.rx_st = serial_port_pkg::RX_IDLE;
      end

      // Shift-register mode: two clocks per bit, clock low then high.
      if (mode == serial_port_pkg::MODE_SHIFT) begin
         s_next.tx_busy = 1'b0;
         s_next.tx_pend = 1'b0;
         if (!s_reg.m0_busy) begin
            s_next.txd    = 1'b1;
            s_next.rxd_oe = 1'b0;
            if (wr_data) begin
               s_next.m0_busy = 1'b1;
               s_next.m0_rx   = 1'b0;
               s_next.m0_sh   = WDATA;
               s_next.m0_bit  = 4'h0;
               s_next.m0_ph   = 1'b0;
               s_next.rxd_oe  = 1'b1;
               s_next.rxd_out = WDATA[0];
               s_next.txd     = 1'b0;
            end else if (s_reg.ctl[`F_RX_EN] && !s_reg.ctl[`F_RX_DONE]) begin
               s_next.m0_busy = 1'b1;
               s_next.m0_rx   = 1'b1;
               s_next.m0_bit  = 4'h0;
               s_next.m0_ph   = 1'b0;
               s_next.txd     = 1'b0;
            end
         end else if (!s_reg.m0_ph) begin
            s_next.m0_ph = 1'b1;
            s_next.txd   = 1'b1;
            if (s_reg.m0_rx) begin
               s_next.m0_sh = {RXD_IN, s_reg.m0_sh[7:1]};
            end
         end else begin
            s_next.m0_ph  = 1'b0;
            s_next.m0_bit = s_reg.m0_bit + 4'h1;
            if (s_reg.m0_bit == `M0_LAST) begin
               s_next.m0_busy = 1'b0;
               s_next.rxd_oe  = 1'b0;
               if (s_reg.m0_rx) begin
                  s_next.rx_buf = s_reg.m0_sh;
                  s_next.ctl[`F_RX_DONE] = 1'b1;
               end else begin
                  s_next.ctl[`F_TX_DONE] = 1'b1;
               end
            end else begin
               s_next.txd = 1'b0;
               if (!s_reg.m0_rx) begin
                  s_next.m0_sh   = {1'b0, s_reg.m0_sh[7:1]};
                  s_next.rxd_out = s_reg.m0_sh[1];
               end
            end
         end
      end else begin
         s_next.m0_busy = 1'b0;
         s_next.rxd_oe  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s_reg         <= '0;
         s_reg.ctl     <= `CTRL_RST;
         s_reg.rate    <= `RATE_RST;
         s_reg.rx_buf  <= `BUF_RST;
         s_reg.rx_st   <= serial_port_pkg::RX_IDLE;
         s_reg.rx_prev <= 1'b1;
         s_reg.txd     <= 1'b1;
         s_reg.rxd_out <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign RDATA   = s_reg.rdata;
   assign TXD     = s_reg.txd;
   assign RXD_OUT = s_reg.rxd_out;
   assign RXD_OE  = s_reg.rxd_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   buf_read_a: assert property (
      RD && ADDR == `DATA_OFS |=> RDATA == $past(s_reg.rx_buf))
      else $error("data read does not return the receive buffer");
   stop_load_a: assert property (
      wr_data && mode == serial_port_pkg::MODE_ASYNC8 |=> s_reg.tx_sh[9] && s_reg.tx_pend)
      else $error("8-bit write did not load a stop value");
   ninth_load_a: assert property (
      wr_data && mode[1] |=> s_reg.tx_sh[9] == $past(s_reg.ctl[`F_TX_B9]))
      else $error("ninth transmit bit not loaded");
   rx_disable_a: assert property (
      !s_reg.ctl[`F_RX_EN] |=> s_reg.rx_st == serial_port_pkg::RX_IDLE)
      else $error("receiver running while disabled");
   tx_done_hold_a: assert property (
      s_reg.ctl[`F_TX_DONE] && !(WR && ADDR == `CTRL_OFS) |=> s_reg.ctl[`F_TX_DONE])
      else $error("transmit done cleared by hardware");
   rx_done_hold_a: assert property (
      s_reg.ctl[`F_RX_DONE] && !(WR && ADDR == `CTRL_OFS) |=> s_reg.ctl[`F_RX_DONE])
      else $error("receive done cleared by hardware");
   start_low_a: assert property (
      s_reg.tx_busy && s_reg.tx_bit == 4'h0 && mode != serial_port_pkg::MODE_SHIFT
      |-> !TXD)
      else $error("start bit not low");
   shift_len_a: assert property (
      $rose(s_reg.m0_busy) && mode == serial_port_pkg::MODE_SHIFT
      |-> ##15 s_reg.m0_busy ##1 !s_reg.m0_busy)
      else $error("shift transfer is not sixteen clocks");
   fix_rate_a: assert property (
      mode == serial_port_pkg::MODE_FIX9 && !dbl && fix_tick ##1 (!dbl) [*4]
      |-> fix_tick && !$past(fix_tick) && !$past(fix_tick, 2)
          && !$past(fix_tick, 3))
      else $error("fixed rate tick not every four clocks");

   stop_flag_a: assert property (
      mode != serial_port_pkg::MODE_SHIFT && s_reg.tx_busy && tx_tick && !wr_data
      && s_reg.tx_sub == `OVS_LAST && s_reg.tx_bit + 4'h1 == tx_last
      |=> TXD && s_reg.ctl[`F_TX_DONE])
      else $error("transmit done not set as the stop bit starts");

   start_abort_a: assert property (
      s_reg.rx_st == serial_port_pkg::RX_START && rx_tick
      && s_reg.rx_sub == `OVS_MID && RXD_IN
      |=> s_reg.rx_st == serial_port_pkg::RX_IDLE)
      else $error("false start bit not abandoned");

   shift_rx_go_a: assert property (
      mode == serial_port_pkg::MODE_SHIFT && !s_reg.m0_busy && !wr_data
      && s_reg.ctl[`F_RX_EN] && !s_reg.ctl[`F_RX_DONE]
      |=> s_reg.m0_busy && s_reg.m0_rx && !TXD)
      else $error("shift reception did not start");

   oe_shift_only_a: assert property (
      RXD_OE |-> $past(mode) == serial_port_pkg::MODE_SHIFT)
      else $error("receive pin driven outside shift mode");

endmodule

/* test/remote_serial.sv */
// Remote serial device that sends frames on the receive pin and captures frames from TXD (async) or the driven receive pin (shift).
`timescale 1ns/1ps
module remote_serial (
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic rxd_out,
   input  wire logic rxd_oe,
   output logic      rxd_drv
);
   logic [10:0] frame;
   int          nbits = 10;
   int          bt = 64;
   bit          sh = 1'b0;
   bit          feed = 1'b0;
   logic [7:0]  feed_data = 8'h00;
   event        got;

   // The line idles high, as a pulled-up serial line does between frames.
   initial rxd_drv = 1'b1;

   task automatic send(input logic [10:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         rxd_drv <= b[i];
         repeat (bt) @(posedge clk);
      end
      rxd_drv <= 1'b1;
      // One idle cycle keeps back-to-back frames apart on the line.
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Asynchronous capture samples each bit at its middle, starting from the start edge.
   initial forever begin
      @(negedge txd);
      if (!sh) begin
         frame = '0;
         repeat (bt / 2) @(posedge clk);
         for (int i = 0; i < nbits; i++) begin
            frame[i] = txd;
            if (i < nbits - 1)
               repeat (bt) @(posedge clk);
         end
         ->got;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shift capture takes the data pin on each rising shift clock while it is driven.
   initial forever begin
      logic [7:0] sr;
      for (int i = 0; i < 8; i++) begin
         @(posedge txd iff (sh && rxd_oe));
         sr[i] = rxd_out;
      end
      frame = {3'h0, sr};
      ->got;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shift reception: each falling shift clock puts the next bit on the data pin.
   initial forever begin
      for (int i = 0; i < 8; i++) begin
         @(negedge txd iff feed);
         rxd_drv <= feed_data[i];
      end
      @(posedge txd);
      rxd_drv <= 1'b1;
   end
endmodule

/* test/four_mode_serial_port_bench.sv */
// Self-checking bench of the four-mode serial port against a remote serial device.
`timescale 1ns/1ps
module four_mode_serial_port_bench;
   logic        CLK;
   logic        RST;
   logic        WR;
   logic        RD;
   logic        T1_OVF;
   logic        T2_OVF;
   logic [1:0]  ADDR;
   logic [1:0]  cnt;
   logic [7:0]  WDATA;
   logic [7:0]  RDATA;
   logic [7:0]  d1;
   logic [7:0]  d2;
   logic        RXD_OUT;
   logic        RXD_OE;
   logic        TXD;
   logic        rd_d;
   wire logic   rxd_drv;
   wire logic   RXD_IN = RXD_OE ? RXD_OUT : rxd_drv;
   logic [7:0]  rq[$];
   logic [10:0] fq[$];
   int          fails = 0;
   int          cmp_count = 0;

   four_mode_serial_port dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .T1_OVF(T1_OVF), .T2_OVF(T2_OVF), .RXD_IN(RXD_IN),
      .RXD_OUT(RXD_OUT), .RXD_OE(RXD_OE), .TXD(TXD));
   remote_serial far_u (.clk(CLK), .txd(TXD), .rxd_out(RXD_OUT), .rxd_oe(RXD_OE),
      .rxd_drv(rxd_drv));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      rq.push_back(e);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(posedge CLK);
   endtask

   task automatic check(input logic [10:0] got, input logic [10:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe, so they are taken there.
   always @(posedge CLK) begin
      if (rd_d)
         check({3'h0, RDATA}, {3'h0, rq.pop_front()}, "read");
      rd_d <= RD;
   end

   initial forever begin
      @(far_u.got);
      check(far_u.frame, fq.pop_front(), "frame");
   end

   // Both timers overflow every four clocks, on different phases.
   always @(posedge CLK) begin
      cnt <= cnt + 2'h1;
      T1_OVF <= cnt == 2'h0;
      T2_OVF <= cnt == 2'h2;
   end

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   initial begin
      repeat (20000) @(posedge CLK);
      fails++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      RST = 1'b1;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 2'h0;
      WDATA = 8'h00;
      cnt = 2'h0;
      T1_OVF = 1'b0;
      T2_OVF = 1'b0;
      rd_d = 1'b0;
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      void'($urandom(69));
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      wr(2'h3, 8'hff);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      rd(2'h3, 8'h00);
      $display("test reset done");
      wr(2'h2, 8'h80);
      wr(2'h0, 8'h88);
      far_u.bt = 32;
      far_u.nbits = 11;
      fq.push_back({1'b1, 1'b1, d1, 1'b0});
      wr(2'h1, d1);
      repeat (400) @(posedge CLK);
      rd(2'h0, 8'h8a);
      $display("test fixed rate transmit done");
      wr(2'h2, 8'h00);
      wr(2'h0, 8'hb0);
      far_u.bt = 64;
      far_u.send({1'b0, 1'b0, d1, 1'b0}, 11);
      rd(2'h0, 8'hb0);
      far_u.send({1'b1, 1'b1, d2, 1'b0}, 11);
      rd(2'h0, 8'hb5);
      rd(2'h1, d2);
      wr(2'h0, 8'h80);
      far_u.send({1'b1, 1'b1, d1, 1'b0}, 11);
      rd(2'h0, 8'h80);
      rd(2'h1, d2);
      $display("test fixed rate receive done");
      wr(2'h2, 8'h80);
      wr(2'h0, 8'h50);
      far_u.nbits = 10;
      fq.push_back({1'b0, 1'b1, d1, 1'b0});
      wr(2'h1, d1);
      far_u.send({2'b01, d2, 1'b0}, 10);
      far_u.send({2'b01, d1, 1'b0}, 10);
      rd(2'h0, 8'h57);
      rd(2'h1, d1);
      $display("test eight bit mode done");
      wr(2'h2, 8'h03);
      wr(2'h0, 8'hd0);
      // A short low pulse must be dropped as a false start bit.
      far_u.bt = 8;
      far_u.send(11'h7fe, 1);
      far_u.bt = 64;
      repeat (48) @(posedge CLK);
      far_u.nbits = 11;
      fq.push_back({1'b1, 1'b0, d2, 1'b0});
      wr(2'h1, d2);
      far_u.send({1'b1, 1'b0, d1, 1'b0}, 11);
      repeat (100) @(posedge CLK);
      rd(2'h0, 8'hd3);
      rd(2'h1, d1);
      $display("test variable nine bit mode done");
      wr(2'h0, 8'h00);
      far_u.sh = 1'b1;
      fq.push_back({3'h0, d1});
      wr(2'h1, d1);
      repeat (24) @(posedge CLK);
      rd(2'h0, 8'h02);
      far_u.feed_data = d2;
      far_u.feed = 1'b1;
      wr(2'h0, 8'h10);
      repeat (24) @(posedge CLK);
      far_u.feed = 1'b0;
      rd(2'h0, 8'h11);
      rd(2'h1, d2);
      $display("test shift mode done");
      repeat (4) @(posedge CLK);
      if (fq.size() != 0) begin
         fails++;
         $display("MISMATCH at %0t: %0d expected frames never seen", $time, fq.size());
      end
      close_out();
   end
endmodule
